// ===== rtl/sarseq_pkg.sv
// Shared constants and types of the simultaneous SAR conversion sequencer
package sarseq_pkg;
  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned NUM_CH    = 8;
  localparam int unsigned RES_BITS  = 18;
  localparam int unsigned RANGE_W   = 3;
  localparam int unsigned CH_W      = 3;
  localparam int unsigned FIFO_W    = CH_W + RANGE_W + RES_BITS;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned SYNC_LEN  = 3;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RANGE  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DATA   = 8'h0C;

  // Control fields
  localparam int unsigned CTRL_NAP_BIT  = 0;
  localparam int unsigned CTRL_PD_BIT   = 1;
  localparam int unsigned CTRL_LANE_LSB = 4;
  localparam logic [2:0]  LANE_RESET    = 3'h0;
  localparam logic [23:0] RANGE_RESET   = 24'hFFFFFF;

  // Status fields
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_READY_BIT = 1;
  localparam int unsigned ST_LVDS_BIT  = 2;
  localparam int unsigned ST_NAP_BIT   = 3;
  localparam int unsigned ST_PD_BIT    = 4;
  localparam int unsigned DATA_VALID_BIT = 31;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ    = 100;
  localparam int unsigned SETTLE_NS  = 40;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STEP_CYC   = SETTLE_CYC + SYNC_LEN;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEL,
    ST_RUN,
    ST_PUSH
  } sarseq_state_t;
endpackage

// ===== rtl/sarseq_stream_if.sv
// Valid/ready word stream between the sequencer and its result FIFO
`timescale 1ns/1ps
`default_nettype none
interface sarseq_stream_if #(
  parameter int unsigned W = 24
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // sarseq_stream_if
`default_nettype wire

// ===== rtl/sarseq_fifo.sv
// Result FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sarseq_fifo #(
  parameter int unsigned W     = 24,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // Fill and drain sides
  sarseq_stream_if.snk      in_s,
  sarseq_stream_if.src      out_s
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic          do_push;
  logic          do_pop;

  assign in_s.ready  = (count != FULL);
  assign out_s.valid = (count != '0);
  assign out_s.data  = mem[rd_ptr];
  assign do_push     = in_s.valid && in_s.ready;
  assign do_pop      = out_s.valid && out_s.ready;

  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sarseq_fifo
`default_nettype wire

// ===== rtl/sarseq_sar.sv
// Successive-approximation search engine for one channel at a time
`timescale 1ns/1ps
`default_nettype none
module sarseq_sar #(
  parameter int unsigned BITS = 18,
  parameter int unsigned STEP = 7
) (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rstn,
  // Control
  input  wire logic            start,
  input  wire logic            cmp_high,
  // Results
  output logic [BITS-1:0]      trial,
  output logic                 done,
  output logic [BITS-1:0]      result
);
  localparam logic [BITS-1:0] TOP = {1'b1, {(BITS-1){1'b0}}};
  localparam int unsigned     SW  = $clog2(STEP + 1);
  localparam logic [SW-1:0]   SLAST = SW'(STEP - 1);

  logic            busy;
  logic [BITS-1:0] mask;
  logic [SW-1:0]   wait_cnt;
  logic [BITS-1:0] kept;

  // Comparator high means the held input lies at or above the trial level
  assign kept = cmp_high ? trial : (trial & ~mask);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy     <= 1'b0;
      mask     <= '0;
      trial    <= '0;
      wait_cnt <= '0;
      done     <= 1'b0;
      result   <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy     <= 1'b1;
        mask     <= TOP;
        trial    <= TOP;
        wait_cnt <= '0;
      end else if (busy) begin
        if (wait_cnt == SLAST) begin
          wait_cnt <= '0;
          mask     <= mask >> 1;
          if (mask[0]) begin
            busy   <= 1'b0;
            done   <= 1'b1;
            result <= kept;
            trial  <= '0;
          end else begin
            trial <= kept | (mask >> 1);
          end
        end else begin
          wait_cnt <= wait_cnt + 1'b1;
        end
      end
    end
  end
endmodule // sarseq_sar
`default_nettype wire

// ===== rtl/sarseq_top.sv
// Simultaneous-sampling SAR conversion sequencer with Wishbone registers
// Notes on behaviour
// - Channels track their inputs while idle until a conversion is requested.
// - Rising conversion-start edge holds all channels at once and starts converting.
// - Channels resolved in turn, 18 trial weights from half scale to 1/262144.
// - Results are offered for readout only after all channels are resolved.
// - Each result divides its channel span into two to the eighteenth levels.
// - Range codes may change between conversions; next conversion uses them.
// - Disabled channels are skipped, shortening the conversion.
// - Bipolar codes 7, 6, 3, 2 give two's complement results.
// - Unipolar codes 5, 4, 1 give straight binary results.
// - Bipolar codes select spans of 2.5 or 1.25 reference, optionally /1.024.
// - Unipolar codes select zero to 2.5, 2.5/1.024 or 1.25 reference.
// - Held sample is discarded after conversion; every conversion samples anew.
// - A pin selects CMOS or LVDS serial port; both ends use it. Here it only sets lvds_mode and the status LVDS bit.
// - CMOS mode supports one to eight output lanes.
// - Optional nap and power-down states cut consumption while idle.
// - Eight 3-bit range codes form one 24-bit configuration word.
`timescale 1ns/1ps
`default_nettype none
module sarseq_top #(
  parameter int unsigned NUM_CH     = sarseq_pkg::NUM_CH,
  parameter int unsigned RES_BITS   = sarseq_pkg::RES_BITS,
  parameter int unsigned FIFO_DEPTH = sarseq_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // Pins and comparator
  input  wire logic                 conversion_start_pin,
  input  wire logic                 lvds_select_pin,
  input  wire logic                 comparator_high,
  // Analog control
  output logic [NUM_CH-1:0]         sample_hold,
  output logic [RES_BITS-1:0]       weighted_capacitor_dac,
  output logic [2:0]                dac_channel,
  output logic [2:0]                dac_span,
  // Status
  output logic                      busy,
  output logic                      nap_active,
  output logic                      power_down_active,
  output logic                      lvds_mode,
  output logic [2:0]                lane_count,
  output logic                      data_ready
);
  localparam int unsigned RW  = sarseq_pkg::RANGE_W;
  localparam int unsigned CW  = sarseq_pkg::CH_W;
  localparam int unsigned FW  = sarseq_pkg::FIFO_W;
  localparam int unsigned NS  = 3;
  localparam logic [CW-1:0] CH_LAST = CW'(NUM_CH - 1);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] pin_clean;

  assign pin_raw = {comparator_high, lvds_select_pin, conversion_start_pin};

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      logic s1;
      logic s2;
      logic s3;
      logic stable;
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          s1     <= 1'b0;
          s2     <= 1'b0;
          s3     <= 1'b0;
          stable <= 1'b0;
        end else begin
          s1 <= pin_raw[gi];
          s2 <= s1;
          s3 <= s2;
          // A level counts once the last two stages agree
          if (s2 == s3) begin
            stable <= s3;
          end
        end
      end
      assign pin_clean[gi] = stable;
    end
  endgenerate

  logic start_level;
  logic start_prev;
  logic start_edge;
  logic cmp_clean;

  assign start_level = pin_clean[0];
  assign cmp_clean   = pin_clean[2];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      start_prev <= 1'b0;
      lvds_mode  <= 1'b0;
    end else begin
      start_prev <= start_level;
      lvds_mode  <= pin_clean[1];
    end
  end

  assign start_edge = start_level && !start_prev;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [23:0]  range_cfg;
  logic         ctrl_nap;
  logic         ctrl_pd;
  logic         bus_req;
  logic         bus_wr;
  logic         bus_rd;
  logic         pop;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr  = bus_req && wb_we_i;
  assign bus_rd  = bus_req && !wb_we_i;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      range_cfg  <= sarseq_pkg::RANGE_RESET;
      ctrl_nap   <= 1'b0;
      ctrl_pd    <= 1'b0;
      lane_count <= sarseq_pkg::LANE_RESET;
    end else if (bus_wr) begin
      if (wb_adr_i == sarseq_pkg::ADDR_CTRL) begin
        if (wb_sel_i[0]) begin
          ctrl_nap   <= wb_dat_i[sarseq_pkg::CTRL_NAP_BIT];
          ctrl_pd    <= wb_dat_i[sarseq_pkg::CTRL_PD_BIT];
          lane_count <= wb_dat_i[sarseq_pkg::CTRL_LANE_LSB +: 3];
        end
      end else if (wb_adr_i == sarseq_pkg::ADDR_RANGE) begin
        // Byte lanes split at bits 8 and 16, so lanes 0 and 1 share channel 2's code, lanes 1 and 2 channel 5's
        if (wb_sel_i[0]) begin
          range_cfg[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          range_cfg[15:8] <= wb_dat_i[15:8];
        end
        if (wb_sel_i[2]) begin
          range_cfg[23:16] <= wb_dat_i[23:16];
        end
      end
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  sarseq_pkg::sarseq_state_t state;
  logic [CW-1:0]       chan;
  logic [23:0]         active_range;
  logic [RW-1:0]       chan_code;
  logic                sar_start;
  logic                sar_done;
  logic [RES_BITS-1:0] sar_result;
  logic [RES_BITS-1:0] result [NUM_CH];
  logic                push_ready;

  assign chan_code = active_range[chan*RW +: RW];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state        <= sarseq_pkg::ST_IDLE;
      chan         <= '0;
      active_range <= '0;
      sar_start    <= 1'b0;
    end else begin
      sar_start <= 1'b0;
      case (state)
        sarseq_pkg::ST_IDLE: begin
          // Busy states do not look at the edge at all
          if (start_edge && !ctrl_pd) begin
            active_range <= range_cfg;
            chan         <= '0;
            state        <= sarseq_pkg::ST_SEL;
          end
        end
        sarseq_pkg::ST_SEL: begin
          if (chan_code == '0) begin
            // One cycle per skipped channel
            if (chan == CH_LAST) begin
              chan  <= '0;
              state <= sarseq_pkg::ST_PUSH;
            end else begin
              chan <= chan + 1'b1;
            end
          end else begin
            sar_start <= 1'b1;
            state     <= sarseq_pkg::ST_RUN;
          end
        end
        sarseq_pkg::ST_RUN: begin
          if (sar_done) begin
            if (chan == CH_LAST) begin
              chan  <= '0;
              state <= sarseq_pkg::ST_PUSH;
            end else begin
              chan  <= chan + 1'b1;
              state <= sarseq_pkg::ST_SEL;
            end
          end
        end
        sarseq_pkg::ST_PUSH: begin
          // Stalls while the FIFO is full
          if (push_ready) begin
            if (chan == CH_LAST) begin
              chan  <= '0;
              state <= sarseq_pkg::ST_IDLE;
            end else begin
              chan <= chan + 1'b1;
            end
          end
        end
        default: begin
          state <= sarseq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Sample and hold
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sample_hold <= '0;
    end else if (state == sarseq_pkg::ST_IDLE) begin
      if (start_edge && !ctrl_pd) begin
        sample_hold <= '1;
      end else begin
        sample_hold <= '0;
      end
    end else if (state == sarseq_pkg::ST_SEL && chan_code == '0) begin
      sample_hold[chan] <= 1'b0;
    end else if (state == sarseq_pkg::ST_RUN && sar_done) begin
      // Released sample is dropped; next start takes a fresh one
      sample_hold[chan] <= 1'b0;
    end
  end

  // ****************************************************************
  // Search engine and result formatting
  // ****************************************************************
  sarseq_sar #(
    .BITS (RES_BITS),
    .STEP (sarseq_pkg::STEP_CYC)
  ) u_sar (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .start    (sar_start),
    .cmp_high (cmp_clean),
    .trial    (weighted_capacitor_dac),
    .done     (sar_done),
    .result   (sar_result)
  );

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dac_channel <= '0;
      dac_span    <= '0;
    end else begin
      dac_channel <= chan;
      // Span code scales the capacitor DAC reference for this channel
      dac_span    <= chan_code;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        result[i] <= '0;
      end
    end else if (state == sarseq_pkg::ST_SEL && chan_code == '0) begin
      result[chan] <= '0;
    end else if (state == sarseq_pkg::ST_RUN && sar_done) begin
      // Bit 1 of the code is set exactly for the bipolar spans
      if (chan_code[1]) begin
        result[chan] <= sar_result ^ {1'b1, {(RES_BITS-1){1'b0}}};
      end else begin
        result[chan] <= sar_result;
      end
    end
  end

  // ****************************************************************
  // Result FIFO
  // ****************************************************************
  sarseq_stream_if #(.W(FW)) push_s ();
  sarseq_stream_if #(.W(FW)) pull_s ();

  assign push_s.valid = (state == sarseq_pkg::ST_PUSH);
  assign push_s.data  = {chan, chan_code, result[chan]};
  assign push_ready   = push_s.ready;
  assign pull_s.ready = pop;

  sarseq_fifo #(
    .W     (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .in_s    (push_s),
    .out_s   (pull_s)
  );

  assign pop = bus_rd && (wb_adr_i == sarseq_pkg::ADDR_DATA) && pull_s.valid;

  // ****************************************************************
  // Status and bus answer
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy              <= 1'b0;
      nap_active        <= 1'b0;
      power_down_active <= 1'b0;
      data_ready        <= 1'b0;
    end else begin
      busy              <= (state != sarseq_pkg::ST_IDLE);
      // Nap lifts by itself for a conversion
      nap_active        <= ctrl_nap && (state == sarseq_pkg::ST_IDLE);
      power_down_active <= ctrl_pd && (state == sarseq_pkg::ST_IDLE);
      data_ready        <= pull_s.valid;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_rd) begin
        wb_dat_o <= '0;
        if (wb_adr_i == sarseq_pkg::ADDR_CTRL) begin
          wb_dat_o[sarseq_pkg::CTRL_NAP_BIT]       <= ctrl_nap;
          wb_dat_o[sarseq_pkg::CTRL_PD_BIT]        <= ctrl_pd;
          wb_dat_o[sarseq_pkg::CTRL_LANE_LSB +: 3] <= lane_count;
        end else if (wb_adr_i == sarseq_pkg::ADDR_RANGE) begin
          wb_dat_o[23:0] <= range_cfg;
        end else if (wb_adr_i == sarseq_pkg::ADDR_STATUS) begin
          wb_dat_o[sarseq_pkg::ST_BUSY_BIT]  <= (state != sarseq_pkg::ST_IDLE);
          wb_dat_o[sarseq_pkg::ST_READY_BIT] <= pull_s.valid;
          wb_dat_o[sarseq_pkg::ST_LVDS_BIT]  <= lvds_mode;
          wb_dat_o[sarseq_pkg::ST_NAP_BIT]   <= nap_active;
          wb_dat_o[sarseq_pkg::ST_PD_BIT]    <= power_down_active;
        end else if (wb_adr_i == sarseq_pkg::ADDR_DATA) begin
          if (pull_s.valid) begin
            wb_dat_o[FW-1:0] <= pull_s.data;
            wb_dat_o[sarseq_pkg::DATA_VALID_BIT] <= 1'b1;
          end
        end
      end
    end
  end
endmodule // sarseq_top
`default_nettype wire

// ===== tb/sarseq_front_model.sv
// Analog front-end model: per-channel track and hold with a comparator
`timescale 1ns/1ps
`default_nettype none
module sarseq_front_model (
  // Clock
  input  wire logic             sys_clk,
  // Converter side
  input  wire logic [7:0]       sample_hold,
  input  wire logic [17:0]      weighted_capacitor_dac,
  input  wire logic [2:0]       dac_channel,
  // Stimulus and answer
  input  wire logic [7:0][17:0] ain,
  output logic                  comparator_high
);
  logic [7:0][17:0] held;

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (!sample_hold[i]) begin
        held[i] <= ain[i];
      end
    end
  end

  // Outside hold the answer is junk, so it toggles rather than sitting still
  assign comparator_high = sample_hold[dac_channel] ?
                           (held[dac_channel] >= weighted_capacitor_dac) : sys_clk;
endmodule // sarseq_front_model
`default_nettype wire

// ===== tb/sarseq_top_monitor.sv
// Port-level assertions for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sarseq_monitor #(
  parameter int unsigned NUM_CH   = 8,
  parameter int unsigned RES_BITS = 18
) (
  // Clock and reset
  input wire logic                sys_clk,
  input wire logic                rstn,
  // Bus handshake
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  // Converter
  input wire logic [NUM_CH-1:0]   sample_hold,
  input wire logic [RES_BITS-1:0] weighted_capacitor_dac,
  input wire logic                busy,
  input wire logic                power_down_active,
  input wire logic                data_ready
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_hold_go; (sample_hold == '0) ##1 (sample_hold != '0); endsequence
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_ans; s_req |=> wb_ack_o; endproperty
  a_ack_ans: assert property (p_ack_ans) else $error("request not acked");
  property p_hold_all; s_hold_go |-> &sample_hold; endproperty
  a_hold_all: assert property (p_hold_all) else $error("hold not all at once");
  property p_hold_seq; sample_hold != '0 |=> (sample_hold & ~$past(sample_hold)) == '0;
  endproperty
  a_hold_seq: assert property (p_hold_seq) else $error("hold rose mid-run");
  property p_dac_first;
    $past(weighted_capacitor_dac) == '0 && weighted_capacitor_dac != '0
      |-> weighted_capacitor_dac == {1'b1, {(RES_BITS - 1){1'b0}}};
  endproperty
  a_dac_first: assert property (p_dac_first) else $error("first trial not half");
  property p_dac_idle; !busy && !$past(busy) |-> weighted_capacitor_dac == '0; endproperty
  a_dac_idle: assert property (p_dac_idle) else $error("trial while idle");
  property p_ready; $rose(data_ready) |-> sample_hold == '0; endproperty
  a_ready: assert property (p_ready) else $error("data before all done");
  property p_pd; power_down_active |-> !busy && sample_hold == '0; endproperty
  a_pd: assert property (p_pd) else $error("busy in power down");
endmodule // sarseq_monitor

bind sarseq_top sarseq_monitor #(.NUM_CH(NUM_CH), .RES_BITS(RES_BITS)) u_mon (
  .sys_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sample_hold,
  .weighted_capacitor_dac, .busy, .power_down_active, .data_ready
);
`default_nettype wire

// ===== tb/sarseq_top_tb.sv
// Self-checking bench of the SAR conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sarseq_top_tb;
  logic             sys_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, busy;
  logic             conversion_start_pin, lvds_select_pin, comparator_high, lvds_mode;
  logic             nap_active, power_down_active, data_ready;
  logic [7:0]       wb_adr_i, sample_hold;
  logic [3:0]       wb_sel_i;
  logic [31:0]      wb_dat_i, wb_dat_o, rd;
  logic [17:0]      weighted_capacitor_dac;
  logic [2:0]       dac_channel, dac_span, lane_count;
  logic [7:0][17:0] ain;
  logic [7:0][17:0] row_ain [3];
  logic [23:0]      row_rng [3];
  int               num_errors, cmp_count;

  sarseq_top dut (
    .sys_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .conversion_start_pin, .lvds_select_pin, .comparator_high,
    .sample_hold, .weighted_capacitor_dac, .dac_channel, .dac_span, .busy, .nap_active,
    .power_down_active, .lvds_mode, .lane_count, .data_ready
  );
  sarseq_front_model u_fe (
    .sys_clk, .sample_hold, .weighted_capacitor_dac, .dac_channel, .ain, .comparator_high
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ********
  // Tasks
  // ********
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic hang(input string nm);
    num_errors++;
    $display("ERROR %s expected done seen timeout", nm);
    give_verdict();
  endtask

  // Entered just after a rising edge; leaves the bus idle for one cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) hang("wb ack");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic pulse(input int n);
    conversion_start_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    conversion_start_pin <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic convert(input int r);
    int          en;
    int          hi;
    logic        bip;
    logic [2:0]  code;
    logic [17:0] res;
    en = 0;
    hi = 0;
    for (int c = 0; c < 8; c++) en += int'(row_rng[r][3*c +: 3] != 3'h0);
    ain <= row_ain[r];
    wb(1'b1, sarseq_pkg::ADDR_RANGE, {8'h00, row_rng[r]});
    conversion_start_pin <= 1'b1;
    for (int k = 0; k < 3000; k++) begin
      @(posedge sys_clk);
      if (k == 6 || k == 66) conversion_start_pin <= 1'b0;
      // Inputs move after the hold, so a stale or fresh sample shows up
      if (k == 60 && en > 0) begin
        conversion_start_pin <= 1'b1;
        ain <= ~row_ain[r];
      end
      if (weighted_capacitor_dac == 18'h20000)
        chk("span", 32'(row_rng[r][3*dac_channel +: 3]), 32'(dac_span));
      if (busy === 1'b1) hi++;
      else if (hi > 0) break;
    end
    if (busy !== 1'b0 || hi == 0) hang("conversion");
    chk("busy span", 32'h1, 32'(hi >= en * 126 && hi <= en * 140 + 40));
    for (int c = 0; c < 8; c++) begin
      code = row_rng[r][3*c +: 3];
      bip = code inside {3'h7, 3'h6, 3'h3, 3'h2};
      res = (code == 3'h0) ? 18'h0 : row_ain[r][c] ^ {bip, 17'h0};
      wb(1'b0, sarseq_pkg::ADDR_DATA, 32'h0);
      chk("data", {1'b1, 7'h00, 3'(c), code, res}, rd);
    end
    wb(1'b0, sarseq_pkg::ADDR_DATA, 32'h0);
    chk("empty", 32'h0, rd);
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    rstn = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    conversion_start_pin = 1'b0;
    lvds_select_pin = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    row_rng[0] = 24'h053977;
    row_rng[1] = 24'hFAC688;
    row_rng[2] = 24'h000000;
    row_ain[0] = {18'h3FFFE, 18'h00001, 18'h2ABCD, 18'h12345,
                  18'h1FFFF, 18'h20000, 18'h00000, 18'h3FFFF};
    row_ain[1] = {18'h30303, 18'h0F0F0, 18'h20000, 18'h1FFFF,
                  18'h3FFFF, 18'h00000, 18'h2AAAA, 18'h15555};
    row_ain[2] = row_ain[0];
    ain = row_ain[2];
    repeat (8) @(posedge sys_clk);
    chk("reset outs", 32'h0, 32'({busy, data_ready, sample_hold}));
    rstn <= 1'b1;
    @(posedge sys_clk);
    wb(1'b0, sarseq_pkg::ADDR_RANGE, 32'h0);
    chk("range reset", {8'h00, sarseq_pkg::RANGE_RESET}, rd);
    wb(1'b1, sarseq_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    wb(1'b0, sarseq_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (int r = 0; r < 3; r++) convert(r);
    // Second run finds the FIFO full and must wait in its push phase
    pulse(100);
    pulse(100);
    chk("stall busy", 32'h3, 32'({busy, data_ready}));
    for (int i = 0; i < 16; i++) begin
      wb(1'b0, sarseq_pkg::ADDR_DATA, 32'h0);
      chk("drain", {1'b1, 7'h00, 3'(i), 21'h0}, rd);
    end
    wb(1'b0, sarseq_pkg::ADDR_DATA, 32'h0);
    chk("drained", 32'h0, rd);
    wb(1'b1, sarseq_pkg::ADDR_CTRL, 32'h2);
    pulse(100);
    wb(1'b0, sarseq_pkg::ADDR_STATUS, 32'h0);
    chk("pd status", 32'h10, rd);
    wb(1'b1, sarseq_pkg::ADDR_CTRL, 32'h71);
    lvds_select_pin <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk("modes", 32'h2F, 32'({nap_active, power_down_active, lvds_mode, lane_count}));
    wb(1'b0, sarseq_pkg::ADDR_STATUS, 32'h0);
    chk("nap status", 32'h0C, rd);
    wb(1'b1, sarseq_pkg::ADDR_RANGE, 32'h7);
    pulse(20);
    chk("nap start", 32'h1, 32'(busy));
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("mid reset", 32'h0, 32'({busy, data_ready, sample_hold}));
    rstn <= 1'b1;
    @(posedge sys_clk);
    wb(1'b0, sarseq_pkg::ADDR_RANGE, 32'h0);
    chk("range again", {8'h00, sarseq_pkg::RANGE_RESET}, rd);
    give_verdict();
  end
endmodule // sarseq_top_tb
`default_nettype wire
